// ### verilog/tcsm_defs.vh
// Constants for the split-mode timer control block
`ifndef TCSM_DEFS_VH
`define TCSM_DEFS_VH
// Register byte offsets
`define TCSM_A_CTRL   6'h00
`define TCSM_A_OEN    6'h01
`define TCSM_A_OVAL   6'h02
`define TCSM_A_SPLIT  6'h03
`define TCSM_A_CMDCLR 6'h04
`define TCSM_A_CMDSET 6'h05
`define TCSM_A_INTEN  6'h0a
`define TCSM_A_INTFL  6'h0b
`define TCSM_A_DBG    6'h0e
`define TCSM_A_LOW_COUNTER   6'h20
`define TCSM_A_HIGH_COUNTER   6'h21
`define TCSM_A_LOW_PERIOD   6'h26
`define TCSM_A_HIGH_PERIOD   6'h27
`define TCSM_A_LOW_COMPARE_0  6'h28
`define TCSM_A_HIGH_COMPARE_0  6'h29
`define TCSM_A_LOW_COMPARE_1  6'h2a
`define TCSM_A_HIGH_COMPARE_1  6'h2b
`define TCSM_A_LOW_COMPARE_2  6'h2c
`define TCSM_A_HIGH_COMPARE_2  6'h2d
// Control A fields
`define TCSM_B_ENABLE 0
`define TCSM_F_PSEL   3:1
`define TCSM_B_RSTDBY 7
`define TCSM_M_CTRL   8'h8f
// Output enable / value layouts
`define TCSM_F_LOW3   2:0
`define TCSM_F_HIGH3  6:4
`define TCSM_M_CH     8'h77
// Split select and debug
`define TCSM_B_SPLIT  0
`define TCSM_B_DBGRUN 0
// Command registers
`define TCSM_F_CMD    3:2
`define TCSM_F_CMDEN  1:0
`define TCSM_CMD_RESTART 2'h2
`define TCSM_CMD_RESET   2'h3
`define TCSM_CMDEN_BOTH  2'h3
// Interrupt bits
`define TCSM_B_LUNF   0
`define TCSM_B_HUNF   1
`define TCSM_F_LCMP   6:4
`define TCSM_M_INT    8'h73
// Reset values
`define TCSM_RST_ZERO 8'h00
`define TCSM_RST_PER  8'hff
// Prescaler terminal counts (divisor minus one)
`define TCSM_DIV1    10'h000
`define TCSM_DIV2    10'h001
`define TCSM_DIV4    10'h003
`define TCSM_DIV8    10'h007
`define TCSM_DIV16   10'h00f
`define TCSM_DIV64   10'h03f
`define TCSM_DIV256  10'h0ff
`define TCSM_DIV1024 10'h3ff
`endif

// ### verilog/tcsm_presc.v
// Peripheral clock prescaler producing count ticks
`include "tcsm_defs.vh"
module tcsm_presc (
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_b_i,
  // Control
  input  wire       run_i,
  input  wire [2:0] prescale_select_i,
  // Tick out
  output wire       tick_o
);
  reg  [9:0] div_cnt_q;
  reg  [9:0] div_cnt_d;
  reg  [9:0] term;

  // Terminal count per select code
  always @*
  begin
    case (prescale_select_i)
      3'h0:    term = `TCSM_DIV1;
      3'h1:    term = `TCSM_DIV2;
      3'h2:    term = `TCSM_DIV4;
      3'h3:    term = `TCSM_DIV8;
      3'h4:    term = `TCSM_DIV16;
      3'h5:    term = `TCSM_DIV64;
      3'h6:    term = `TCSM_DIV256;
      default: term = `TCSM_DIV1024;
    endcase
  end

  assign tick_o = run_i & (div_cnt_q >= term);

  always @*
  begin
    if (!run_i)
      div_cnt_d = 10'h000;
    else if (tick_o)
      div_cnt_d = 10'h000;
    else
      div_cnt_d = div_cnt_q + 10'h001;
  end

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      div_cnt_q <= 10'h000;
    else
      div_cnt_q <= div_cnt_d;
  end
endmodule

// ### verilog/tcsm_cnt8.v
// One 8-bit down counter with three compare channels
`include "tcsm_defs.vh"
module tcsm_cnt8 (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_b_i,
  // Counting
  input  wire        tick_i,
  input  wire        wrap_i,
  input  wire        load_i,
  input  wire [7:0]  load_val_i,
  input  wire [7:0]  per_i,
  input  wire [23:0] cmp_i,
  // State out
  output wire [7:0]  cnt_o,
  output wire        unf_o,
  output wire [2:0]  match_o,
  output wire [2:0]  wave_o
);
  reg  [7:0] cnt_q;
  reg  [2:0] wave_q;
  wire       zero;

  assign zero  = (cnt_q == 8'h00);
  assign unf_o = tick_i & zero & wrap_i;
  assign cnt_o = cnt_q;
  assign wave_o = wave_q;

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_q <= `TCSM_RST_ZERO;
    else if (load_i)
      cnt_q <= load_val_i;
    else if (tick_i)
      cnt_q <= zero ? (wrap_i ? per_i : 8'hff) : cnt_q - 8'h01;
  end

  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1)
    begin : g_ch
      assign match_o[k] = tick_i & (cnt_q == cmp_i[8*k+7:8*k]);
      always @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          wave_q[k] <= 1'b0;
        else
          wave_q[k] <= (cnt_q < cmp_i[8*k+7:8*k]);
      end
    end
  endgenerate
endmodule

// ### verilog/tcsm_ctrl.v
// Split-mode timer control: registers, counters and pin override
// Behaviour
// - Run-in-standby set keeps counting during standby sleep; clear stops it there.
// - Select bits 3:1 divide peripheral clock by 1,2,4,8,16,64,256,1024.
// - Control A bit 0 enables counting; zero keeps the timer disabled.
// - In split mode, high compare n enable drives waveform pin n+3 instead of port value.
// - Split map: counters 0x20/0x21, periods 0x26/0x27, compare pairs from 0x28.
// - Split select makes two independent 8-bit counters using the split map.
// - In split mode, low compare n enable drives waveform pin n instead of port value.
`include "tcsm_defs.vh"
module tcsm_ctrl (
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_b_i,
  // Register port
  input  wire [5:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_we_i,
  input  wire       reg_re_i,
  output wire [7:0] reg_rdata_o,
  // System state
  input  wire       standby_i,
  input  wire       debug_halt_i,
  // Port pins
  input  wire [5:0] port_out_i,
  output wire [5:0] waveform_pin_o,
  // Interrupt
  output wire       irq_o
);
  // Software registers
  reg  [7:0] control_a_q;
  reg  [7:0] output_enable_control_q;
  reg  [7:0] output_value_control_q;
  reg        split_select_q;
  reg  [1:0] cmd_enable_q;
  reg  [7:0] interrupt_enable_q;
  reg  [7:0] interrupt_flags_q;
  reg  [7:0] interrupt_flags_d;
  reg        dbg_run_q;
  reg  [7:0] low_period_q;
  reg  [7:0] high_period_q;
  reg  [23:0] low_cmp_q;
  reg  [23:0] high_cmp_q;
  reg  [7:0] rdata_q;
  reg  [7:0] rdata_d;
  reg  [5:0] pin_q;
  reg  [5:0] pin_d;

  // Decoded fields
  wire       enable;
  wire       run_in_standby;
  wire [2:0] prescale_select;
  wire [2:0] high_compare_output_enable;
  wire [2:0] low_compare_output_enable;

  // Command decode
  wire       wr_cmd;
  wire [1:0] cmd_val;
  wire [1:0] cmd_en;
  wire       cmd_both;
  wire       do_restart;
  wire       do_hard_reset;

  // Counter wiring
  wire       run;
  wire       tick;
  wire [7:0] low_cnt;
  wire [7:0] high_cnt;
  wire       low_unf;
  wire       high_unf;
  wire [2:0] low_match;
  wire [2:0] high_match;
  wire [2:0] low_wave;
  wire [2:0] high_wave;
  wire       low_tick;
  wire       high_tick;
  wire       low_wrap;
  wire       low_load;
  wire       high_load;
  wire [7:0] low_load_val;
  wire [7:0] high_load_val;
  wire       wr_low_cnt;
  wire       wr_high_cnt;

  assign enable          = control_a_q[`TCSM_B_ENABLE];
  assign run_in_standby  = control_a_q[`TCSM_B_RSTDBY];
  assign prescale_select = control_a_q[`TCSM_F_PSEL];
  assign low_compare_output_enable  = output_enable_control_q[`TCSM_F_LOW3];
  assign high_compare_output_enable = output_enable_control_q[`TCSM_F_HIGH3];

  // Count gating by enable, standby and debug halt
  assign run = enable
             & (~standby_i | run_in_standby)
             & (~debug_halt_i | dbg_run_q);

  tcsm_presc u_presc (
    .clk_sys_i         (clk_sys_i),
    .rst_b_i           (rst_b_i),
    .run_i             (run),
    .prescale_select_i (prescale_select),
    .tick_o            (tick)
  );

  // Commands arrive through the set and clear registers
  assign wr_cmd   = reg_we_i & ((reg_addr_i == `TCSM_A_CMDSET) | (reg_addr_i == `TCSM_A_CMDCLR));
  assign cmd_val  = reg_wdata_i[`TCSM_F_CMD];
  assign cmd_en   = (reg_addr_i == `TCSM_A_CMDSET) ? (cmd_enable_q | reg_wdata_i[`TCSM_F_CMDEN])
                                                  : cmd_enable_q;
  assign cmd_both = (cmd_en == `TCSM_CMDEN_BOTH);
  assign do_restart    = wr_cmd & cmd_both & (cmd_val == `TCSM_CMD_RESTART);
  assign do_hard_reset = wr_cmd & cmd_both & (cmd_val == `TCSM_CMD_RESET) & ~enable;

  // Split: independent counters; otherwise low and high chain into 16 bits
  assign low_tick  = tick;
  assign high_tick = split_select_q ? tick : (tick & (low_cnt == 8'h00));
  assign low_wrap  = split_select_q | (high_cnt == 8'h00);

  assign wr_low_cnt  = reg_we_i & (reg_addr_i == `TCSM_A_LOW_COUNTER);
  assign wr_high_cnt = reg_we_i & (reg_addr_i == `TCSM_A_HIGH_COUNTER);
  assign low_load  = do_restart | do_hard_reset | wr_low_cnt;
  assign high_load = do_restart | do_hard_reset | wr_high_cnt;
  assign low_load_val  = do_restart ? low_period_q :
                         (do_hard_reset ? `TCSM_RST_ZERO : reg_wdata_i);
  assign high_load_val = do_restart ? high_period_q :
                         (do_hard_reset ? `TCSM_RST_ZERO : reg_wdata_i);

  tcsm_cnt8 u_low (
    .clk_sys_i  (clk_sys_i),
    .rst_b_i    (rst_b_i),
    .tick_i     (low_tick),
    .wrap_i     (low_wrap),
    .load_i     (low_load),
    .load_val_i (low_load_val),
    .per_i      (low_period_q),
    .cmp_i      (low_cmp_q),
    .cnt_o      (low_cnt),
    .unf_o      (low_unf),
    .match_o    (low_match),
    .wave_o     (low_wave)
  );

  tcsm_cnt8 u_high (
    .clk_sys_i  (clk_sys_i),
    .rst_b_i    (rst_b_i),
    .tick_i     (high_tick),
    .wrap_i     (1'b1),
    .load_i     (high_load),
    .load_val_i (high_load_val),
    .per_i      (high_period_q),
    .cmp_i      (high_cmp_q),
    .cnt_o      (high_cnt),
    .unf_o      (high_unf),
    .match_o    (high_match),
    .wave_o     (high_wave)
  );

  // Control registers
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      control_a_q             <= `TCSM_RST_ZERO;
      output_enable_control_q <= `TCSM_RST_ZERO;
      output_value_control_q  <= `TCSM_RST_ZERO;
      split_select_q          <= 1'b0;
      cmd_enable_q            <= 2'h0;
      interrupt_enable_q      <= `TCSM_RST_ZERO;
      dbg_run_q               <= 1'b0;
    end
    else if (do_hard_reset)
    begin
      control_a_q             <= `TCSM_RST_ZERO;
      output_enable_control_q <= `TCSM_RST_ZERO;
      output_value_control_q  <= `TCSM_RST_ZERO;
      cmd_enable_q            <= 2'h0;
      interrupt_enable_q      <= `TCSM_RST_ZERO;
    end
    else if (reg_we_i)
    begin
      case (reg_addr_i)
        `TCSM_A_CTRL:   control_a_q <= reg_wdata_i & `TCSM_M_CTRL;
        `TCSM_A_OEN:    output_enable_control_q <= reg_wdata_i & `TCSM_M_CH;
        `TCSM_A_OVAL:   output_value_control_q <= reg_wdata_i & `TCSM_M_CH;
        `TCSM_A_SPLIT:  split_select_q <= reg_wdata_i[`TCSM_B_SPLIT];
        `TCSM_A_CMDSET: cmd_enable_q <= cmd_enable_q | reg_wdata_i[`TCSM_F_CMDEN];
        `TCSM_A_CMDCLR: cmd_enable_q <= cmd_enable_q & ~reg_wdata_i[`TCSM_F_CMDEN];
        `TCSM_A_INTEN:  interrupt_enable_q <= reg_wdata_i & `TCSM_M_INT;
        `TCSM_A_DBG:    dbg_run_q <= reg_wdata_i[`TCSM_B_DBGRUN];
        default:        split_select_q <= split_select_q;
      endcase
    end
  end

  // Period and compare registers, split map
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      low_period_q  <= `TCSM_RST_PER;
      high_period_q <= `TCSM_RST_PER;
      low_cmp_q     <= {3{`TCSM_RST_ZERO}};
      high_cmp_q    <= {3{`TCSM_RST_ZERO}};
    end
    else if (do_hard_reset)
    begin
      low_period_q  <= `TCSM_RST_PER;
      high_period_q <= `TCSM_RST_PER;
      low_cmp_q     <= {3{`TCSM_RST_ZERO}};
      high_cmp_q    <= {3{`TCSM_RST_ZERO}};
    end
    else if (reg_we_i)
    begin
      case (reg_addr_i)
        `TCSM_A_LOW_PERIOD:  low_period_q <= reg_wdata_i;
        `TCSM_A_HIGH_PERIOD:  high_period_q <= reg_wdata_i;
        `TCSM_A_LOW_COMPARE_0: low_cmp_q[7:0] <= reg_wdata_i;
        `TCSM_A_HIGH_COMPARE_0: high_cmp_q[7:0] <= reg_wdata_i;
        `TCSM_A_LOW_COMPARE_1: low_cmp_q[15:8] <= reg_wdata_i;
        `TCSM_A_HIGH_COMPARE_1: high_cmp_q[15:8] <= reg_wdata_i;
        `TCSM_A_LOW_COMPARE_2: low_cmp_q[23:16] <= reg_wdata_i;
        `TCSM_A_HIGH_COMPARE_2: high_cmp_q[23:16] <= reg_wdata_i;
        default:       low_period_q <= low_period_q;
      endcase
    end
  end

  // Sticky flags: hardware set wins over a write-one clear
  always @*
  begin
    interrupt_flags_d = interrupt_flags_q;
    if (reg_we_i && (reg_addr_i == `TCSM_A_INTFL))
      interrupt_flags_d = interrupt_flags_q & ~reg_wdata_i;
    if (do_hard_reset)
      interrupt_flags_d = `TCSM_RST_ZERO;
    interrupt_flags_d[`TCSM_B_LUNF] = interrupt_flags_d[`TCSM_B_LUNF] | low_unf;
    interrupt_flags_d[`TCSM_B_HUNF] = interrupt_flags_d[`TCSM_B_HUNF] | (high_unf & split_select_q);
    interrupt_flags_d[`TCSM_F_LCMP] = interrupt_flags_d[`TCSM_F_LCMP] | (low_match & {3{split_select_q}});
  end

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      interrupt_flags_q <= `TCSM_RST_ZERO;
    else
      interrupt_flags_q <= interrupt_flags_d & `TCSM_M_INT;
  end

  assign irq_o = |(interrupt_flags_q & interrupt_enable_q);

  // Waveform pin override; disabled timer shows the output value bits
  always @*
  begin
    pin_d = port_out_i;
    if (split_select_q)
    begin
      if (low_compare_output_enable[0])
        pin_d[0] = enable ? low_wave[0] : output_value_control_q[0];
      if (low_compare_output_enable[1])
        pin_d[1] = enable ? low_wave[1] : output_value_control_q[1];
      if (low_compare_output_enable[2])
        pin_d[2] = enable ? low_wave[2] : output_value_control_q[2];
      if (high_compare_output_enable[0])
        pin_d[3] = enable ? high_wave[0] : output_value_control_q[4];
      if (high_compare_output_enable[1])
        pin_d[4] = enable ? high_wave[1] : output_value_control_q[5];
      if (high_compare_output_enable[2])
        pin_d[5] = enable ? high_wave[2] : output_value_control_q[6];
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pin_q <= 6'h00;
    else
      pin_q <= pin_d;
  end

  assign waveform_pin_o = pin_q;

  // Read mux, answer one cycle later; command field reads zero
  always @*
  begin
    case (reg_addr_i)
      `TCSM_A_CTRL:   rdata_d = control_a_q;
      `TCSM_A_OEN:    rdata_d = output_enable_control_q;
      `TCSM_A_OVAL:   rdata_d = output_value_control_q;
      `TCSM_A_SPLIT:  rdata_d = {7'h00, split_select_q};
      `TCSM_A_CMDCLR: rdata_d = {6'h00, cmd_enable_q};
      `TCSM_A_CMDSET: rdata_d = {6'h00, cmd_enable_q};
      `TCSM_A_INTEN:  rdata_d = interrupt_enable_q;
      `TCSM_A_INTFL:  rdata_d = interrupt_flags_q;
      `TCSM_A_DBG:    rdata_d = {7'h00, dbg_run_q};
      `TCSM_A_LOW_COUNTER:   rdata_d = low_cnt;
      `TCSM_A_HIGH_COUNTER:   rdata_d = high_cnt;
      `TCSM_A_LOW_PERIOD:   rdata_d = low_period_q;
      `TCSM_A_HIGH_PERIOD:   rdata_d = high_period_q;
      `TCSM_A_LOW_COMPARE_0:  rdata_d = low_cmp_q[7:0];
      `TCSM_A_HIGH_COMPARE_0:  rdata_d = high_cmp_q[7:0];
      `TCSM_A_LOW_COMPARE_1:  rdata_d = low_cmp_q[15:8];
      `TCSM_A_HIGH_COMPARE_1:  rdata_d = high_cmp_q[15:8];
      `TCSM_A_LOW_COMPARE_2:  rdata_d = low_cmp_q[23:16];
      `TCSM_A_HIGH_COMPARE_2:  rdata_d = high_cmp_q[23:16];
      default:        rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_q <= 8'h00;
    else if (reg_re_i)
      rdata_q <= rdata_d;
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata_o = rdata_q;
endmodule

// ### dv/tcsm_ctrl_assertions.sv
// Port checker for the split-mode timer control
module tcsm_ctrl_assertions (
  // Clock and reset
  input logic       clk_sys_i,
  input logic       rst_b_i,
  // Register port
  input logic [5:0] reg_addr_i,
  input logic [7:0] reg_wdata_i,
  input logic       reg_we_i,
  input logic       reg_re_i,
  input logic [7:0] reg_rdata_o,
  // Pins and interrupt
  input logic [5:0] port_out_i,
  input logic [5:0] waveform_pin_o,
  input logic       irq_o
);
  logic [7:0] ctrl_q;
  logic [7:0] oen_q;
  logic [7:0] ie_q;
  logic       split_q;
  logic [2:0] idle_q;
  wire        hole   = reg_addr_i inside {[6'h06:6'h09], 6'h0c, 6'h0d, [6'h0f:6'h1f],
                                          [6'h22:6'h25], [6'h2e:6'h3f]};
  wire        wr_ctl = reg_we_i && reg_addr_i == 6'h00;
  wire        wr_oen = reg_we_i && reg_addr_i == 6'h01;
  wire        rd_ctl = reg_re_i && reg_addr_i == 6'h00;
  wire        rd_oen = reg_re_i && reg_addr_i == 6'h01;
  wire        rd_spl = reg_re_i && reg_addr_i == 6'h03;
  wire        rd_cnt = reg_re_i && reg_addr_i == 6'h20;
  wire [5:0]  oen6   = {oen_q[6:4], oen_q[2:0]};

  // Shadow of the written control state
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_q  <= 8'h00;
      oen_q   <= 8'h00;
      ie_q    <= 8'h00;
      split_q <= 1'b0;
      idle_q  <= 3'h0;
    end
    else
    begin
      if (wr_ctl) ctrl_q <= reg_wdata_i;
      if (wr_oen) oen_q <= reg_wdata_i;
      if (reg_we_i && reg_addr_i == 6'h0a) ie_q <= reg_wdata_i;
      if (reg_we_i && reg_addr_i == 6'h03) split_q <= reg_wdata_i[0];
      idle_q <= ctrl_q[0] ? 3'h0 : (idle_q == 3'h7 ? idle_q : idle_q + 3'h1);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  chk_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  chk_hole_zero: assert property (reg_re_i && hole |=> reg_rdata_o == 8'h00)
    else $error("unmapped address read not zero");
  chk_ctrl_back: assert property (wr_ctl ##1 rd_ctl |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h8f))
    else $error("control A readback wrong");
  chk_oen_back: assert property (wr_oen ##1 rd_oen |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h77))
    else $error("output enable readback wrong");
  chk_split_bit: assert property (rd_spl |=> reg_rdata_o == {7'h00, $past(split_q)})
    else $error("split select readback wrong");
  chk_port_pass: assert property (!split_q |=> waveform_pin_o == $past(port_out_i))
    else $error("pins do not follow port outside split");
  chk_pin_mask: assert property (split_q |=> ((waveform_pin_o ^ $past(port_out_i)) & ~$past(oen6)) == 6'h00)
    else $error("pin without enable not from port");
  chk_count_hold: assert property (rd_cnt && idle_q >= 3'h4 ##1 rd_cnt |=> reg_rdata_o == $past(reg_rdata_o))
    else $error("counter moved while disabled");
  chk_irq_mask: assert property (ie_q == 8'h00 |-> !irq_o)
    else $error("interrupt with all sources masked");
  chk_irq_clear: assert property (reg_we_i && reg_addr_i == 6'h0b && reg_wdata_i == 8'hff && idle_q == 3'h7
    |=> !irq_o)
    else $error("interrupt stays after flag clear");

  cov_irq: cover property (irq_o);
  cov_override: cover property (split_q && oen_q != 8'h00);
  cov_hold: cover property (rd_cnt ##1 rd_cnt);
endmodule

bind tcsm_ctrl tcsm_ctrl_assertions tcsm_ctrl_assertions_i (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .port_out_i, .waveform_pin_o, .irq_o);

// ### dv/tb.sv
// Self-checking bench for the split-mode timer control
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys_i    = 1'b0;
  logic       rst_b_i      = 1'b0;
  logic [5:0] reg_addr_i   = 6'h00;
  logic [7:0] reg_wdata_i  = 8'h00;
  logic       reg_we_i     = 1'b0;
  logic       reg_re_i     = 1'b0;
  logic       standby_i    = 1'b0;
  logic       debug_halt_i = 1'b0;
  logic [5:0] port_out_i   = 6'h00;
  wire  [7:0] reg_rdata_o;
  wire  [5:0] waveform_pin_o;
  wire        irq_o;
  logic [7:0] rd_v;
  int         dv [8]       = '{1, 2, 4, 8, 16, 64, 256, 1024};
  int         miscompares  = 0;
  int         tests_run    = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  tcsm_ctrl tcsm_ctrl_i (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .standby_i, .debug_halt_i, .port_out_i, .waveform_pin_o, .irq_o);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  // Write leaves the strobe up so writes may follow back to back
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
  begin
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge clk_sys_i);
  end
  endtask

  task automatic idle(input int n);
  begin
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
  end
  endtask

  task automatic rd(input logic [5:0] a);
  begin
    reg_addr_i <= a;
    reg_we_i   <= 1'b0;
    reg_re_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_re_i <= 1'b0;
    #1 rd_v = reg_rdata_o;
    @(posedge clk_sys_i);
  end
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
  begin
    rd(a);
    chk(rd_v, e);
  end
  endtask

  // Run for n cycles from 0x80, then two reads back to back
  task automatic cnt_run(input logic [7:0] c, input int n, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] d;
  begin
    wr(6'h20, 8'h80);
    wr(6'h00, c);
    idle(n);
    wr(6'h00, 8'h00);
    idle(4);
    reg_addr_i <= 6'h20;
    reg_re_i   <= 1'b1;
    @(posedge clk_sys_i);
    #1 rd_v = reg_rdata_o;
    @(posedge clk_sys_i);
    reg_re_i <= 1'b0;
    #1 chk(reg_rdata_o, rd_v);
    d = 8'h80 - rd_v;
    chk(d, ((d >= lo) && (d <= hi)) === 1'b1 ? d : lo);
    @(posedge clk_sys_i);
  end
  endtask

  task automatic pin_chk(input logic [5:0] e);
  begin
    idle(3);
    @(negedge clk_sys_i);
    chk({2'h0, waveform_pin_o}, {2'h0, e});
    @(posedge clk_sys_i);
  end
  endtask

  task automatic t_reset;
  begin
    for (logic [6:0] a = 7'h00; a < 7'h30; a++) rdc(a[5:0], (a == 7'h26 || a == 7'h27) ? 8'hff : 8'h00);
    $display("reset values done");
  end
  endtask

  task automatic t_map;
  begin
    wr(6'h00, 8'hfe);
    rdc(6'h00, 8'h8e);
    wr(6'h01, 8'hff);
    rdc(6'h01, 8'h77);
    wr(6'h03, 8'hff);
    rdc(6'h03, 8'h01);
    for (logic [6:0] a = 7'h20; a < 7'h2e; a++) wr(a[5:0], {2'h2, a[5:0]});
    for (logic [6:0] a = 7'h20; a < 7'h2e; a++) rdc(a[5:0], (a > 7'h21 && a < 7'h26) ? 8'h00 : {2'h2, a[5:0]});
    $display("register map done");
  end
  endtask

  task automatic t_count;
  begin
    wr(6'h03, 8'h01);
    for (int i = 0; i < 8; i++) cnt_run({4'h0, i[2:0], 1'b1}, 8 * dv[i] - 1, 8'h07, 8'h09);
    cnt_run(8'h80, 40, 8'h00, 8'h00);
    standby_i <= 1'b1;
    cnt_run(8'h01, 7, 8'h00, 8'h00);
    cnt_run(8'h81, 7, 8'h07, 8'h09);
    standby_i <= 1'b0;
    debug_halt_i <= 1'b1;
    cnt_run(8'h01, 7, 8'h00, 8'h00);
    debug_halt_i <= 1'b0;
    $display("counting done");
  end
  endtask

  task automatic t_pins;
  begin
    port_out_i <= 6'h2a;
    wr(6'h03, 8'h00);
    wr(6'h02, 8'h25);
    wr(6'h01, 8'h77);
    pin_chk(6'h2a);
    wr(6'h03, 8'h01);
    pin_chk(6'h15);
    wr(6'h01, 8'h70);
    pin_chk(6'h12);
    wr(6'h01, 8'h07);
    pin_chk(6'h2d);
    $display("pin override done");
  end
  endtask

  task automatic t_irq;
  begin
    wr(6'h26, 8'h03);
    wr(6'h20, 8'h01);
    wr(6'h0b, 8'hff);
    wr(6'h00, 8'h01);
    idle(12);
    wr(6'h00, 8'h00);
    idle(4);
    rd(6'h0b);
    chk(rd_v & 8'h01, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    wr(6'h0a, 8'h01);
    idle(2);
    chk({7'h00, irq_o}, 8'h01);
    wr(6'h0b, 8'hff);
    idle(2);
    chk({7'h00, irq_o}, 8'h00);
    rd(6'h0b);
    chk(rd_v & 8'h01, 8'h00);
    $display("interrupt done");
  end
  endtask

  // Restart loads periods, hard reset while disabled restores reset values but keeps split select
  task automatic t_cmd;
  begin
    wr(6'h26, 8'h10);
    wr(6'h05, 8'h0b);
    rdc(6'h05, 8'h03);
    rdc(6'h20, 8'h10);
    wr(6'h04, 8'h0f);
    rdc(6'h26, 8'hff);
    rdc(6'h20, 8'h00);
    rdc(6'h04, 8'h00);
    rdc(6'h03, 8'h01);
    $display("commands done");
  end
  endtask

  task automatic results;
  begin
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset;
    t_map;
    t_count;
    t_pins;
    t_irq;
    t_cmd;
    idle(2);
    results;
  end
endmodule
